/* capm_ctrl.v */
`timescale 1ns/1ps
`include "capm_regs.vh"
module capm_ctrl (
  input wire core_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`CAPM_AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg sidetone_en,
  output reg [4:0] sidetone_atten_db,
  output reg mic_gain_off,
  output reg [5:0] mic_gain_half_db,
  output wire anti_alias_filter_pwr,
  output wire anti_image_filter_pwr,
  output wire [1:0] enc_dac_pwr,
  output wire [1:0] dec_dac_pwr,
  output wire [1:0] mic_amp_pwr,
  output wire [1:0] digital_gain_amp_pwr,
  output wire [1:0] vol_amp_pwr,
  output reg bandgap_en,
  output reg oscillator_power_save,
  output reg [4:0] mode_onehot,
  output reg buffered_io,
  output reg mode_reserved
);
  reg [7:0] sidetone_q;
  reg [7:0] mic_path_gain_q;
  reg [7:0] analog_power_one_q;
  reg [7:0] analog_power_two_q;
  reg [7:0] coding_mode_select_q;
  reg [1:0] flags_q;
  reg [1:0] flags_d;
  reg err_q;
  reg [31:0] rdata_d;
  reg mapped;
  wire [`CAPM_PWR_W-1:0] pwr_raw;
  wire [`CAPM_PWR_W-1:0] pwr_gated;
  wire setup;
  wire wr_en;
  wire lane0;
  wire [7:0] wbyte;

  function hit;
    input [`CAPM_AW-1:0] a;
    input [7:0] idx;
    begin
      hit = (a == {idx, 2'b00});
    end
  endfunction

  function rsvd_set;
    input [7:0] data;
    input [7:0] mask;
    begin
      rsvd_set = |(data & ~mask);
    end
  endfunction

  // Zero-wait slave: read data is latched in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_q;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & ~err_q;
  assign lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];

  always @* begin
    mapped = hit(paddr, `CAPM_IDX_RESET) | hit(paddr, `CAPM_IDX_SIDETONE) |
             hit(paddr, `CAPM_IDX_MIC_GAIN) | hit(paddr, `CAPM_IDX_PWR_ONE) |
             hit(paddr, `CAPM_IDX_PWR_TWO) | hit(paddr, `CAPM_IDX_MODE) |
             hit(paddr, `CAPM_IDX_STATUS) | hit(paddr, `CAPM_IDX_FLAGS);
    rdata_d = 32'h0000_0000;
    if (hit(paddr, `CAPM_IDX_SIDETONE)) begin
      rdata_d[7:0] = sidetone_q;
    end else if (hit(paddr, `CAPM_IDX_MIC_GAIN)) begin
      rdata_d[7:0] = mic_path_gain_q;
    end else if (hit(paddr, `CAPM_IDX_PWR_ONE)) begin
      rdata_d[7:0] = analog_power_one_q;
    end else if (hit(paddr, `CAPM_IDX_PWR_TWO)) begin
      rdata_d[7:0] = analog_power_two_q;
    end else if (hit(paddr, `CAPM_IDX_MODE)) begin
      rdata_d[7:0] = coding_mode_select_q;
    end else if (hit(paddr, `CAPM_IDX_STATUS)) begin
      rdata_d[15:0] = {bandgap_en, oscillator_power_save, mode_reserved, buffered_io,
                       pwr_gated};
    end else if (hit(paddr, `CAPM_IDX_FLAGS)) begin
      rdata_d[1:0] = flags_q;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      err_q <= ~mapped | (pwrite & hit(paddr, `CAPM_IDX_STATUS));
    end
  end

  // Reserved bits are never stored, so they read back as zero
  always @(posedge core_clk) begin
    if (srst) begin
      sidetone_q <= `CAPM_RST_VAL;
      mic_path_gain_q <= `CAPM_RST_VAL;
      analog_power_one_q <= `CAPM_RST_VAL;
      analog_power_two_q <= `CAPM_RST_VAL;
      coding_mode_select_q <= `CAPM_RST_VAL;
    end else if (wr_en & hit(paddr, `CAPM_IDX_RESET)) begin
      // The command carries no data, so strobes are not looked at
      sidetone_q <= `CAPM_RST_VAL;
      mic_path_gain_q <= `CAPM_RST_VAL;
      analog_power_one_q <= `CAPM_RST_VAL;
      analog_power_two_q <= `CAPM_RST_VAL;
      coding_mode_select_q <= `CAPM_RST_VAL;
    end else if (wr_en & lane0) begin
      if (hit(paddr, `CAPM_IDX_SIDETONE)) begin
        sidetone_q <= wbyte & `CAPM_MASK_SIDETONE;
      end
      if (hit(paddr, `CAPM_IDX_MIC_GAIN)) begin
        mic_path_gain_q <= wbyte & `CAPM_MASK_MIC_GAIN;
      end
      if (hit(paddr, `CAPM_IDX_PWR_ONE)) begin
        analog_power_one_q <= wbyte & `CAPM_MASK_PWR_ONE;
      end
      if (hit(paddr, `CAPM_IDX_PWR_TWO)) begin
        analog_power_two_q <= wbyte & `CAPM_MASK_PWR_TWO;
      end
      if (hit(paddr, `CAPM_IDX_MODE)) begin
        coding_mode_select_q <= wbyte & `CAPM_MASK_MODE;
      end
    end
  end

  // Sticky flags for software slips; a new slip wins over a same-cycle clear
  always @* begin
    flags_d = flags_q;
    if (wr_en & lane0 & hit(paddr, `CAPM_IDX_FLAGS)) begin
      flags_d = flags_q & ~wbyte[1:0];
    end
    if (wr_en & lane0) begin
      if ((hit(paddr, `CAPM_IDX_MIC_GAIN) & rsvd_set(wbyte, `CAPM_MASK_MIC_GAIN)) |
          (hit(paddr, `CAPM_IDX_PWR_ONE) & rsvd_set(wbyte, `CAPM_MASK_PWR_ONE)) |
          (hit(paddr, `CAPM_IDX_MODE) & rsvd_set(wbyte, `CAPM_MASK_MODE))) begin
        flags_d[`CAPM_FLAG_RSVD_BIT] = 1'b1;
      end
      if (hit(paddr, `CAPM_IDX_MODE) & (wbyte[`CAPM_MODE_MSB:0] > `CAPM_MODE_ALAW)) begin
        flags_d[`CAPM_FLAG_MODE_BIT] = 1'b1;
      end
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      flags_q <= 2'b00;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Bypass does not remove power; software must keep filters on itself
  assign pwr_raw = {analog_power_one_q[`CAPM_AAF_BIT],
                    analog_power_one_q[`CAPM_AIF_BIT],
                    analog_power_one_q[`CAPM_ENC_MSB:`CAPM_ENC_LSB],
                    analog_power_one_q[`CAPM_DEC_MSB:`CAPM_DEC_LSB],
                    analog_power_two_q[`CAPM_MICAMP_MSB:`CAPM_MICAMP_LSB],
                    analog_power_two_q[`CAPM_DGA_MSB:`CAPM_DGA_LSB],
                    analog_power_two_q[`CAPM_VOL_MSB:`CAPM_VOL_LSB]};

  capm_pwr_gate #(
    .W(`CAPM_PWR_W)
  ) u_gate (
    .core_clk(core_clk),
    .srst(srst),
    .master_en(analog_power_two_q[`CAPM_MASTER_BIT]),
    .field_in(pwr_raw),
    .field_out(pwr_gated)
  );

  assign anti_alias_filter_pwr = pwr_gated[11];
  assign anti_image_filter_pwr = pwr_gated[10];
  assign enc_dac_pwr = pwr_gated[9:8];
  assign dec_dac_pwr = pwr_gated[7:6];
  assign mic_amp_pwr = pwr_gated[5:4];
  assign digital_gain_amp_pwr = pwr_gated[3:2];
  assign vol_amp_pwr = pwr_gated[1:0];

  always @(posedge core_clk) begin
    if (srst) begin
      sidetone_en <= 1'b0;
      sidetone_atten_db <= `CAPM_ST_ATT_0;
      mic_gain_off <= 1'b1;
      mic_gain_half_db <= 6'h00;
      bandgap_en <= 1'b0;
      oscillator_power_save <= 1'b0;
      mode_onehot <= 5'b00001;
      buffered_io <= 1'b0;
      mode_reserved <= 1'b0;
    end else begin
      // Path enable ignores power bits: a powered-down block still passes signal
      sidetone_en <= sidetone_q[`CAPM_ST_EN_BIT];
      case (sidetone_q[`CAPM_ST_GAIN_MSB:`CAPM_ST_GAIN_LSB])
        2'b00: sidetone_atten_db <= `CAPM_ST_ATT_0;
        2'b01: sidetone_atten_db <= `CAPM_ST_ATT_1;
        2'b10: sidetone_atten_db <= `CAPM_ST_ATT_2;
        default: sidetone_atten_db <= `CAPM_ST_ATT_3;
      endcase
      // Half-dB steps, two's complement, unity at code 10000
      mic_gain_off <= (mic_path_gain_q[`CAPM_MIC_GAIN_MSB:`CAPM_MIC_GAIN_LSB] == 5'h00);
      mic_gain_half_db <= {1'b0, mic_path_gain_q[`CAPM_MIC_GAIN_MSB:`CAPM_MIC_GAIN_LSB]}
                          - `CAPM_MIC_UNITY;
      bandgap_en <= analog_power_two_q[`CAPM_MASTER_BIT];
      oscillator_power_save <= analog_power_two_q[`CAPM_OSC_PS_BIT];
      mode_reserved <= 1'b0;
      case (coding_mode_select_q[`CAPM_MODE_MSB:0])
        `CAPM_MODE_ADM_RAW: begin
          mode_onehot <= 5'b00001;
          buffered_io <= 1'b0;
        end
        `CAPM_MODE_ADM_BUF: begin
          mode_onehot <= 5'b00010;
          buffered_io <= 1'b1;
        end
        `CAPM_MODE_LIN: begin
          mode_onehot <= 5'b00100;
          buffered_io <= 1'b1;
        end
        `CAPM_MODE_MULAW: begin
          mode_onehot <= 5'b01000;
          buffered_io <= 1'b1;
        end
        `CAPM_MODE_ALAW: begin
          mode_onehot <= 5'b10000;
          buffered_io <= 1'b1;
        end
        default: begin
          // Reserved codes select nothing rather than guess a mode
          mode_onehot <= 5'b00000;
          buffered_io <= 1'b0;
          mode_reserved <= 1'b1;
        end
      endcase
    end
  end
endmodule

/* capm_ctrl_monitor.sv */
`timescale 1ns/1ps
`include "capm_regs.vh"
module capm_ctrl_monitor (
  input wire core_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`CAPM_AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire pslverr,
  input wire sidetone_en,
  input wire [4:0] sidetone_atten_db,
  input wire mic_gain_off,
  input wire [5:0] mic_gain_half_db,
  input wire anti_alias_filter_pwr,
  input wire anti_image_filter_pwr,
  input wire [1:0] enc_dac_pwr,
  input wire [1:0] dec_dac_pwr,
  input wire [1:0] mic_amp_pwr,
  input wire [1:0] digital_gain_amp_pwr,
  input wire [1:0] vol_amp_pwr,
  input wire bandgap_en,
  input wire oscillator_power_save,
  input wire [4:0] mode_onehot,
  input wire buffered_io,
  input wire mode_reserved
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  wire [11:0] pw = {anti_alias_filter_pwr, anti_image_filter_pwr, enc_dac_pwr, dec_dac_pwr,
    mic_amp_pwr, digital_gain_amp_pwr, vol_amp_pwr};
  function automatic [4:0] att(input [1:0] g);
    att = g == 2'h0 ? 5'h00 : g == 2'h1 ? 5'h09 : g == 2'h2 ? 5'h0F : 5'h15;
  endfunction
  // Only the exact indices answer; a write to the status word is refused too
  wire bus_ok = paddr[1:0] == 2'b00 && !(pwrite && paddr[9:2] == `CAPM_IDX_STATUS) &&
    paddr[9:2] inside {`CAPM_IDX_RESET, `CAPM_IDX_SIDETONE, `CAPM_IDX_MIC_GAIN,
    `CAPM_IDX_PWR_ONE, `CAPM_IDX_PWR_TWO, `CAPM_IDX_MODE, `CAPM_IDX_STATUS, `CAPM_IDX_FLAGS};
  reg [7:0] wd1_q;
  reg [7:0] wd2_q;
  // Write byte delayed to line up with the output two edges after the write
  always @(posedge core_clk) begin
    wd1_q <= pwdata[7:0];
    wd2_q <= wd1_q;
  end
  sequence wr(logic [9:0] a);
    psel && penable && pwrite && pready && pstrb[0] && paddr == a;
  endsequence
  // Store at the write edge, output register one edge later, seen at the next
  property p_st;
    wr({`CAPM_IDX_SIDETONE, 2'b00}) |-> ##2
      (sidetone_atten_db == att(wd2_q[2:1]) && sidetone_en == wd2_q[0]);
  endproperty
  property p_mic;
    wr({`CAPM_IDX_MIC_GAIN, 2'b00}) |-> ##2
      (mic_gain_off == (wd2_q[7:3] == 5'h00) &&
      (wd2_q[7:3] == 5'h00 || mic_gain_half_db == {1'b0, wd2_q[7:3]} - 6'h10));
  endproperty
  property p_mode;
    wr({`CAPM_IDX_MODE, 2'b00}) |-> ##2
      (mode_onehot == (wd2_q[2:0] < 3'h5 ? 5'h01 << wd2_q[2:0] : 5'h00) &&
      buffered_io == (wd2_q[2:0] != 3'h0 && wd2_q[2:0] < 3'h5) &&
      mode_reserved == (wd2_q[2:0] > 3'h4));
  endproperty
  property p_p1;
    wr({`CAPM_IDX_PWR_ONE, 2'b00}) |-> ##2
      (!bandgap_en || pw[11:6] == {wd2_q[6], wd2_q[4], wd2_q[3:0]});
  endproperty
  property p_p2;
    wr({`CAPM_IDX_PWR_TWO, 2'b00}) |-> ##2
      (pw[5:0] == (wd2_q[0] ? wd2_q[7:2] : 6'h00) &&
      oscillator_power_save == wd2_q[1] && bandgap_en == wd2_q[0]);
  endproperty
  a_sidetone_gain: assert property (p_st) else $error("sidetone output wrong");
  a_mic_gain: assert property (p_mic) else $error("mic gain output wrong");
  a_mode_decode: assert property (p_mode) else $error("mode decode wrong");
  a_power_one: assert property (p_p1) else $error("power one levels wrong");
  a_power_two: assert property (p_p2) else $error("power two levels wrong");
  a_master_off: assert property (!bandgap_en |-> pw == 12'h000)
    else $error("power on while master off");
  a_reset_clear: assert property (wr({`CAPM_IDX_RESET, 2'b00}) |-> ##2 (pw == 12'h000 &&
    !bandgap_en && sidetone_atten_db == 5'h00 && !sidetone_en && mic_gain_off &&
    mode_onehot == 5'h01)) else $error("general reset left state");
  a_err_phase: assert property (psel && penable |-> pslverr == !bus_ok)
    else $error("error response wrong");
endmodule

/* capm_pwr_gate.v */
`timescale 1ns/1ps
module capm_pwr_gate #(
  parameter W = 12
) (
  input wire core_clk,
  input wire srst,
  input wire master_en,
  input wire [W-1:0] field_in,
  output reg [W-1:0] field_out
);
  always @(posedge core_clk) begin
    if (srst) begin
      field_out <= {W{1'b0}};
    end else begin
      // A block gets current only while its field and the master are both set
      field_out <= master_en ? field_in : {W{1'b0}};
    end
  end
endmodule

/* capm_regs.vh */
// What this block does
// - Sidetone gain field sets 0/-9/-15/-21 dB
// - Sidetone enable bit turns sidetone path on
// - Mic gain: off, then -7.5dB in 0.5dB steps
// - Power one bit 6 powers anti-alias filter
// - Power one bit 4 powers anti-image filter only
// - Encode DAC level: off, lowest, low, normal
// - Decode DAC level uses same four levels
// - Mic amplifier level in power two bits 7-6
// - Mic digital gain amp level, bits 5-4
// - Volume amp level, power two bits 3-2
// - Oscillator power-save bit powers down oscillator
// - Master enable clear powers down all analog
// - Block powered only with field and master set
// - Power bits never break the signal path
// - Coding mode selects delta modulation or PCM variants
// - General reset command clears all control registers
`ifndef CAPM_REGS_VH
`define CAPM_REGS_VH

`define CAPM_AW 10
`define CAPM_IDX_RESET 8'h01
`define CAPM_IDX_SIDETONE 8'h62
`define CAPM_IDX_MIC_GAIN 8'h63
`define CAPM_IDX_PWR_ONE 8'h64
`define CAPM_IDX_PWR_TWO 8'h65
`define CAPM_IDX_MODE 8'h70
`define CAPM_IDX_STATUS 8'h7E
`define CAPM_IDX_FLAGS 8'h7F

`define CAPM_RST_VAL 8'h00
`define CAPM_MASK_SIDETONE 8'hFF
`define CAPM_MASK_MIC_GAIN 8'hF8
`define CAPM_MASK_PWR_ONE 8'h5F
`define CAPM_MASK_PWR_TWO 8'hFF
`define CAPM_MASK_MODE 8'h07

`define CAPM_ST_EN_BIT 0
`define CAPM_ST_GAIN_MSB 2
`define CAPM_ST_GAIN_LSB 1
`define CAPM_MIC_GAIN_MSB 7
`define CAPM_MIC_GAIN_LSB 3
`define CAPM_AAF_BIT 6
`define CAPM_AIF_BIT 4
`define CAPM_ENC_MSB 3
`define CAPM_ENC_LSB 2
`define CAPM_DEC_MSB 1
`define CAPM_DEC_LSB 0
`define CAPM_MICAMP_MSB 7
`define CAPM_MICAMP_LSB 6
`define CAPM_DGA_MSB 5
`define CAPM_DGA_LSB 4
`define CAPM_VOL_MSB 3
`define CAPM_VOL_LSB 2
`define CAPM_OSC_PS_BIT 1
`define CAPM_MASTER_BIT 0
`define CAPM_MODE_MSB 2

`define CAPM_MODE_ADM_RAW 3'h0
`define CAPM_MODE_ADM_BUF 3'h1
`define CAPM_MODE_LIN 3'h2
`define CAPM_MODE_MULAW 3'h3
`define CAPM_MODE_ALAW 3'h4

`define CAPM_ST_ATT_0 5'h00
`define CAPM_ST_ATT_1 5'h09
`define CAPM_ST_ATT_2 5'h0F
`define CAPM_ST_ATT_3 5'h15
`define CAPM_MIC_UNITY 6'h10

`define CAPM_FLAG_RSVD_BIT 0
`define CAPM_FLAG_MODE_BIT 1
`define CAPM_PWR_W 12

`endif

/* testbench.sv */
`timescale 1ns/1ps
`include "capm_regs.vh"
module testbench;
  reg core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, er;
  reg [9:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [3:0] pstrb = 0;
  wire [31:0] prdata;
  wire pready, pslverr, st_en, mic_off, aaf, anti_image_filter, bg, osc, bio, mres;
  wire [4:0] att, onehot;
  wire [5:0] half;
  wire [1:0] enc, dec, mamp, dga, vol;
  wire [11:0] pw = {aaf, anti_image_filter, enc, dec, mamp, dga, vol};
  integer fails = 0, checks = 0, i;
  localparam [9:0] A_RST = {`CAPM_IDX_RESET, 2'b00}, A_ST = {`CAPM_IDX_SIDETONE, 2'b00};
  localparam [9:0] A_MIC = {`CAPM_IDX_MIC_GAIN, 2'b00}, A_P1 = {`CAPM_IDX_PWR_ONE, 2'b00};
  localparam [9:0] A_P2 = {`CAPM_IDX_PWR_TWO, 2'b00}, A_MODE = {`CAPM_IDX_MODE, 2'b00};
  localparam [19:0] ATT = {5'h15, 5'h0F, 5'h09, 5'h00};
  capm_ctrl dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sidetone_en(st_en), .sidetone_atten_db(att),
    .mic_gain_off(mic_off), .mic_gain_half_db(half), .anti_alias_filter_pwr(aaf),
    .anti_image_filter_pwr(anti_image_filter), .enc_dac_pwr(enc), .dec_dac_pwr(dec), .mic_amp_pwr(mamp),
    .digital_gain_amp_pwr(dga), .vol_amp_pwr(vol), .bandgap_en(bg),
    .oscillator_power_save(osc), .mode_onehot(onehot), .buffered_io(bio),
    .mode_reserved(mres));
  initial forever #50 core_clk = ~core_clk;
  task finish_test;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Waits three edges after the answer so gated power outputs have settled
  task apb(input [9:0] a, input w, input [7:0] d, input [3:0] s);
    begin
      @(posedge core_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d}; pstrb <= s;
      @(posedge core_clk);
      penable <= 1;
      // No wait count is assumed; only the watchdog ends a stuck access
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
      repeat (3) @(posedge core_clk);
      #1;
    end
  endtask
  initial begin
    #1000000;
    fails = fails + 1;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 0;
    @(posedge core_clk); #1;
    chk("mic_off", 1, mic_off);
    chk("mode", 1, onehot);
    chk("pwr", 0, pw);
    for (i = 0; i < 4; i = i + 1) begin
      apb(A_ST, 1, 8'(i * 2 + 1), 4'hF);
      chk("att", ATT[i * 5 +: 5], att);
      chk("st_en", 1, st_en);
    end
    apb(A_ST, 1, 8'h06, 4'hF);
    chk("st_en", 0, st_en);
    for (i = 0; i < 32; i = i + 1) begin
      apb(A_MIC, 1, 8'(i << 3), 4'hF);
      chk("mic_off", i == 0, mic_off);
      if (i != 0) chk("mic_db", (i - 16) & 32'h3F, half);
    end
    for (i = 0; i < 4; i = i + 1) begin
      apb(A_P2, 1, 8'(i * 84 + 1), 4'hF);
      apb(A_P1, 1, 8'(8'h50 | i * 5), 4'hF);
      chk("pwr", 32'hC00 + i * 32'h155, pw);
      chk("bg", 1, bg);
    end
    apb(A_P2, 1, 8'h03, 4'hF);
    chk("osc", 1, osc);
    chk("pwr", 32'hFC0, pw);
    apb(A_ST, 1, 8'h01, 4'hF);
    apb(A_P2, 1, 8'hFC, 4'hF);
    chk("pwr", 0, pw);
    chk("bg", 0, bg);
    chk("st_en", 1, st_en);
    apb(A_P1, 0, 8'h00, 4'h0);
    chk("rd_p1", 32'h5F, rd);
    for (i = 0; i < 5; i = i + 1) begin
      apb(A_MODE, 1, 8'(i), 4'hF);
      chk("mode", 1 << i, onehot);
      chk("bio", i != 0, bio);
      chk("mres", 0, mres);
    end
    apb(A_MODE, 1, 8'h02, 4'h0);
    chk("mode", 32'h10, onehot);
    apb(10'h3FC, 0, 8'h00, 4'h0);
    chk("slverr", 1, er);
    apb(A_P2, 1, 8'hFD, 4'hF);
    chk("pwr", 32'hFFF, pw);
    apb(A_RST, 1, 8'h00, 4'hF);
    chk("pwr", 0, pw);
    chk("att", 0, att);
    chk("st_en", 0, st_en);
    chk("mode", 1, onehot);
    apb(A_P1, 0, 8'h00, 4'h0);
    chk("rd_p1", 0, rd);
    apb({`CAPM_IDX_FLAGS, 2'b00}, 0, 8'h00, 4'h0);
    chk("flags", 0, rd);
    finish_test;
  end
endmodule
bind capm_ctrl capm_ctrl_monitor u_mon (.core_clk(core_clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .sidetone_en(sidetone_en),
  .sidetone_atten_db(sidetone_atten_db), .mic_gain_off(mic_gain_off),
  .mic_gain_half_db(mic_gain_half_db), .anti_alias_filter_pwr(anti_alias_filter_pwr),
  .anti_image_filter_pwr(anti_image_filter_pwr), .enc_dac_pwr(enc_dac_pwr),
  .dec_dac_pwr(dec_dac_pwr), .mic_amp_pwr(mic_amp_pwr),
  .digital_gain_amp_pwr(digital_gain_amp_pwr), .vol_amp_pwr(vol_amp_pwr),
  .bandgap_en(bandgap_en), .oscillator_power_save(oscillator_power_save),
  .mode_onehot(mode_onehot), .buffered_io(buffered_io), .mode_reserved(mode_reserved));
